// ### common/hdlc_test_map.vh
// Register map and constants of the test and loopback section.
// Assumes an 8-bit register bus with byte offsets.
`ifndef HDLC_TEST_MAP_VH
`define HDLC_TEST_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define TEST_CTRL_OFS 8'h1B
`define TEST_STAT_OFS 8'h1C
`define CRC_CORRUPT_LO_OFS 8'h20
`define CRC_CORRUPT_HI_OFS 8'h21

// ****************************************
// Control field positions
// ****************************************
`define SOFT_RESET_POS 7
`define RX_TO_TX_LOOP_POS 6
`define CRC_TEST_POS 3
`define FIFO_SWAP_POS 2
`define ADDR_TEST_POS 1
`define TX_TO_RX_LOOP_POS 0

// ****************************************
// Reset values and constants
// ****************************************
`define TEST_CTRL_RESET 8'h00
`define CRC_CORRUPT_RESET 16'h0000
`define CRC_REMAINDER_PATTERN 16'hF0B8
`define SHIFT_CYCLES 5'h10
`define LOOP_FIFO_DEPTH 16
`define LOOP_FIFO_AW 4
`define LOOP_WORD_W 10

`endif

// ### core/hdlc_test_loopback_control.v
// Test and loopback section of an HDLC controller, plus its loop FIFO.
// Assumes receiver, transmitter and both packet FIFOs live outside on
// core_clk; serial clocks and line data arrive as asynchronous pins.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "hdlc_test_map.vh"

// ****************************************
// Synchronous FIFO
// ****************************************
module loop_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rst,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_reg;
    reg [AW-1:0] rdPtr_reg;
    reg [AW:0] count_reg;
    reg full_reg;
    reg empty_reg;
    wire push;
    wire pop;
    reg [AW:0] count_next;

    assign inReady = ~full_reg;
    assign outValid = ~empty_reg;
    assign outData = mem[rdPtr_reg];
    assign push = inValid & ~full_reg;
    assign pop = outReady & ~empty_reg;

    always @* begin
        count_next = count_reg;
        if (push & ~pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop & ~push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always @(posedge clk) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            wrPtr_reg <= {AW{1'b0}};
            rdPtr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            full_reg <= 1'b0;
            empty_reg <= 1'b1;
        end else begin
            if (push) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            count_reg <= count_next;
            full_reg <= (count_next == DEPTH[AW:0]);
            empty_reg <= (count_next == {(AW+1){1'b0}});
        end
    end
endmodule // loop_fifo

// ****************************************
// Test and loopback control
// ****************************************
module hdlc_test_loopback_control (
    input wire core_clk,
    input wire sys_rst,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdData,
    input wire rxSerialClock,
    input wire rxLineData,
    input wire txSerialClock,
    input wire txPacketData,
    input wire receiverEnableBit,
    input wire transmitterEnableBit,
    input wire [15:0] stationAddress,
    input wire rxByteValid,
    input wire [7:0] rxByteData,
    input wire [1:0] rxByteTag,
    input wire rxByteIsFraming,
    output reg rxLoopReady,
    input wire cpuTxWrite,
    input wire [7:0] cpuTxData,
    input wire [1:0] cpuTxTag,
    input wire cpuRxRead,
    input wire [7:0] rxFifoOutData,
    input wire [1:0] rxFifoOutTag,
    input wire [7:0] txFifoOutData,
    input wire [1:0] txFifoOutTag,
    input wire txFifoInReady,
    output reg [7:0] cpuReadData,
    output reg [1:0] fifoTagReadBits,
    output reg rxFifoWrite,
    output reg [7:0] rxFifoInData,
    output reg [1:0] rxFifoInTag,
    output reg rxFifoRead,
    output reg txFifoWrite,
    output reg [7:0] txFifoInData,
    output reg [1:0] txFifoInTag,
    output reg txFifoRead,
    output reg receiverSerialIn,
    output reg hdlcReset
);
    reg [7:0] testCtrl_reg;
    reg zeroSeen_reg;
    reg [15:0] crcCorrupt_reg;
    reg [2:0] pinMeta_reg;
    reg [2:0] pinSync_reg;
    reg rxClkPrev_reg;
    reg [15:0] crcShift_reg;
    reg [15:0] addrShift_reg;
    reg [4:0] crcCount_reg;
    reg [4:0] addrCount_reg;
    reg crcTestPrev_reg;
    reg addrTestPrev_reg;
    reg crcMatchFlag_reg;
    reg addressMatchFlag_reg;
    reg rxClockMonitor_reg;
    reg txClockMonitor_reg;
    reg readSwap_reg;
    wire softResetBit;
    wire rxToTxLoopback;
    wire crcRemainderTest;
    wire fifoSwapTest;
    wire addressMatchTest;
    wire txToRxLoopback;
    wire blockReset;
    wire rxClkRise;
    wire serialBit;
    wire [2:0] pinRaw;
    wire loopInValid;
    wire loopInReady;
    wire loopOutValid;
    wire loopOutReady;
    wire [`LOOP_WORD_W-1:0] loopOutData;
    wire ctrlWrite;

    assign softResetBit = testCtrl_reg[`SOFT_RESET_POS];
    assign rxToTxLoopback = testCtrl_reg[`RX_TO_TX_LOOP_POS];
    assign crcRemainderTest = testCtrl_reg[`CRC_TEST_POS];
    assign fifoSwapTest = testCtrl_reg[`FIFO_SWAP_POS];
    assign addressMatchTest = testCtrl_reg[`ADDR_TEST_POS];
    assign txToRxLoopback = testCtrl_reg[`TX_TO_RX_LOOP_POS];
    // Soft reset clears all test state except the control register, its zero-arm flag and the pin synchronisers
    assign blockReset = sys_rst | softResetBit;
    assign ctrlWrite = regWr & (regAddr == `TEST_CTRL_OFS);

    // ****************************************
    // Control register and soft reset
    // ****************************************
    always @(posedge core_clk) begin
        if (sys_rst) begin
            testCtrl_reg <= `TEST_CTRL_RESET;
            zeroSeen_reg <= 1'b0;
        end else if (ctrlWrite) begin
            if (regWrData[`SOFT_RESET_POS]) begin
                testCtrl_reg <= regWrData;
                zeroSeen_reg <= 1'b0;
            end else if (softResetBit & ~zeroSeen_reg) begin
                // First zero only arms; reset bit and test bits hold their written value
                zeroSeen_reg <= 1'b1;
            end else begin
                testCtrl_reg <= regWrData;
                zeroSeen_reg <= 1'b0;
            end
        end
    end

    always @(posedge core_clk) begin
        if (blockReset) begin
            crcCorrupt_reg <= `CRC_CORRUPT_RESET;
        end else if (regWr & (regAddr == `CRC_CORRUPT_LO_OFS)) begin
            crcCorrupt_reg[7:0] <= regWrData;
        end else if (regWr & (regAddr == `CRC_CORRUPT_HI_OFS)) begin
            crcCorrupt_reg[15:8] <= regWrData;
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    assign pinRaw = {txSerialClock, rxLineData, rxSerialClock};
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : gSync
            always @(posedge core_clk) begin
                if (sys_rst) begin
                    pinMeta_reg[i] <= 1'b0;
                    pinSync_reg[i] <= 1'b0;
                end else begin
                    pinMeta_reg[i] <= pinRaw[i];
                    pinSync_reg[i] <= pinMeta_reg[i];
                end
            end
        end
    endgenerate

    assign rxClkRise = pinSync_reg[0] & ~rxClkPrev_reg;
    assign serialBit = txToRxLoopback ? txPacketData : pinSync_reg[1];

    // ****************************************
    // Serial test shifters and status
    // ****************************************
    always @(posedge core_clk) begin
        if (blockReset) begin
            rxClkPrev_reg <= 1'b0;
            crcShift_reg <= 16'h0000;
            addrShift_reg <= 16'h0000;
            crcCount_reg <= 5'h00;
            addrCount_reg <= 5'h00;
            crcTestPrev_reg <= 1'b0;
            addrTestPrev_reg <= 1'b0;
            crcMatchFlag_reg <= 1'b0;
            addressMatchFlag_reg <= 1'b0;
            rxClockMonitor_reg <= 1'b0;
            txClockMonitor_reg <= 1'b0;
            receiverSerialIn <= 1'b0;
        end else begin
            rxClkPrev_reg <= pinSync_reg[0];
            crcTestPrev_reg <= crcRemainderTest;
            addrTestPrev_reg <= addressMatchTest;
            // Shift count restarts each time a test is newly enabled
            if (crcRemainderTest & ~crcTestPrev_reg) begin
                crcCount_reg <= 5'h00;
            end else if (crcRemainderTest & rxClkRise &
                         (crcCount_reg != `SHIFT_CYCLES)) begin
                crcShift_reg <= {crcShift_reg[14:0], serialBit};
                crcCount_reg <= crcCount_reg + 5'h01;
            end
            if (addressMatchTest & ~addrTestPrev_reg) begin
                addrCount_reg <= 5'h00;
            end else if (addressMatchTest & rxClkRise &
                         (addrCount_reg != `SHIFT_CYCLES)) begin
                addrShift_reg <= {addrShift_reg[14:0], serialBit};
                addrCount_reg <= addrCount_reg + 5'h01;
            end
            // Corrupt mask flips expected bits to prove each compare bit
            crcMatchFlag_reg <= (crcShift_reg ==
                (`CRC_REMAINDER_PATTERN ^ crcCorrupt_reg));
            addressMatchFlag_reg <= (addrShift_reg == stationAddress);
            // Raw clock before any zero stuffing stall
            rxClockMonitor_reg <= pinSync_reg[0] & receiverEnableBit;
            txClockMonitor_reg <= pinSync_reg[2] & transmitterEnableBit;
            receiverSerialIn <= serialBit;
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    always @(posedge core_clk) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
            hdlcReset <= 1'b1;
        end else begin
            hdlcReset <= blockReset;
            regRdData <= 8'h00;
            if (regRd) begin
                case (regAddr)
                    `TEST_CTRL_OFS: regRdData <= testCtrl_reg;
                    `TEST_STAT_OFS: regRdData <= {4'h0,
                        rxClockMonitor_reg, txClockMonitor_reg,
                        crcMatchFlag_reg, addressMatchFlag_reg};
                    `CRC_CORRUPT_LO_OFS: regRdData <= crcCorrupt_reg[7:0];
                    `CRC_CORRUPT_HI_OFS: regRdData <= crcCorrupt_reg[15:8];
                    default: regRdData <= 8'h00;
                endcase
            end
        end
    end

    // ****************************************
    // Rx-to-tx loop buffer
    // ****************************************
    // Flags and CRC never enter the loop path
    assign loopInValid = rxToTxLoopback & rxByteValid & ~rxByteIsFraming;
    // Processor writes to the tx FIFO take priority over looped bytes
    assign loopOutReady = txFifoInReady & ~(cpuTxWrite & ~fifoSwapTest);

    loop_fifo #(
        .WIDTH(`LOOP_WORD_W),
        .DEPTH(`LOOP_FIFO_DEPTH),
        .AW(`LOOP_FIFO_AW)
    ) uLoopFifo (
        .clk(core_clk),
        .rst(blockReset),
        .inValid(loopInValid),
        .inReady(loopInReady),
        .inData({rxByteTag, rxByteData}),
        .outValid(loopOutValid),
        .outReady(loopOutReady),
        .outData(loopOutData)
    );

    // ****************************************
    // FIFO write and read steering
    // ****************************************
    always @(posedge core_clk) begin
        if (blockReset) begin
            rxLoopReady <= 1'b0;
            rxFifoWrite <= 1'b0;
            rxFifoInData <= 8'h00;
            rxFifoInTag <= 2'b00;
            txFifoWrite <= 1'b0;
            txFifoInData <= 8'h00;
            txFifoInTag <= 2'b00;
            rxFifoRead <= 1'b0;
            txFifoRead <= 1'b0;
            readSwap_reg <= 1'b0;
            cpuReadData <= 8'h00;
            fifoTagReadBits <= 2'b00;
        end else begin
            rxLoopReady <= loopInReady;
            // Receiver wins over a swapped processor write in one cycle
            if (rxByteValid & ~rxByteIsFraming) begin
                rxFifoWrite <= 1'b1;
                rxFifoInData <= rxByteData;
                rxFifoInTag <= rxByteTag;
            end else if (cpuTxWrite & fifoSwapTest) begin
                rxFifoWrite <= 1'b1;
                rxFifoInData <= cpuTxData;
                rxFifoInTag <= cpuTxTag;
            end else begin
                rxFifoWrite <= 1'b0;
            end
            if (cpuTxWrite & ~fifoSwapTest) begin
                txFifoWrite <= 1'b1;
                txFifoInData <= cpuTxData;
                txFifoInTag <= cpuTxTag;
            end else if (loopOutValid & loopOutReady) begin
                txFifoWrite <= 1'b1;
                txFifoInData <= loopOutData[7:0];
                txFifoInTag <= loopOutData[9:8];
            end else begin
                txFifoWrite <= 1'b0;
            end
            rxFifoRead <= cpuRxRead & ~fifoSwapTest;
            txFifoRead <= cpuRxRead & fifoSwapTest;
            readSwap_reg <= fifoSwapTest;
            if (readSwap_reg) begin
                cpuReadData <= txFifoOutData;
                fifoTagReadBits <= txFifoOutTag;
            end else begin
                cpuReadData <= rxFifoOutData;
                fifoTagReadBits <= rxFifoOutTag;
            end
        end
    end
endmodule // hdlc_test_loopback_control
`default_nettype wire

// ### verif/hdlc_test_asserts.sv
// Checker of the test section ports, bound onto its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
// ****
// Port assertions
// ****
module hdlc_test_asserts (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic hdlcReset,
    input wire logic rxByteValid,
    input wire logic [7:0] rxByteData,
    input wire logic [1:0] rxByteTag,
    input wire logic rxByteIsFraming,
    input wire logic rxFifoWrite,
    input wire logic [7:0] rxFifoInData,
    input wire logic [1:0] rxFifoInTag,
    input wire logic cpuTxWrite,
    input wire logic [7:0] cpuTxData,
    input wire logic [1:0] cpuTxTag,
    input wire logic txFifoWrite,
    input wire logic [1:0] fifoTagReadBits,
    input wire logic [1:0] txFifoOutTag,
    input wire logic txPacketData,
    input wire logic receiverSerialIn
);
    logic [7:0] ctl_reg;
    logic arm_reg;
    wire logic ctlWr = regWr && regAddr == 8'h1B;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Shadow of the control byte; a lone zero write only arms the clear
    always @(posedge core_clk) begin
        if (sys_rst) begin
            ctl_reg <= 8'h00;
            arm_reg <= 1'b0;
        end else if (ctlWr) begin
            arm_reg <= ctl_reg[7] && !regWrData[7] && !arm_reg;
            if (!ctl_reg[7] || regWrData[7] || arm_reg) begin
                ctl_reg <= regWrData;
            end
        end
    end
    property p_soft_set;
        ctlWr && regWrData[7] |-> ##[1:2] hdlcReset;
    endproperty
    a_soft_set: assert property (p_soft_set) else $error("no reset");
    property p_one_zero;
        ctlWr && !regWrData[7] && ctl_reg[7] && !arm_reg |=> hdlcReset [*2];
    endproperty
    a_one_zero: assert property (p_one_zero) else $error("cleared");
    property p_rx_byte;
        rxByteValid && !rxByteIsFraming && !ctl_reg[2] && !ctl_reg[7]
            && !hdlcReset |=> rxFifoWrite && rxFifoInTag == $past(rxByteTag)
            && rxFifoInData == $past(rxByteData);
    endproperty
    a_rx_byte: assert property (p_rx_byte) else $error("rx byte");
    property p_framing;
        rxByteValid && rxByteIsFraming && !cpuTxWrite |=> !rxFifoWrite;
    endproperty
    a_framing: assert property (p_framing) else $error("framing");
    property p_looped;
        ctl_reg[6] && !ctl_reg[7] && rxByteValid && !rxByteIsFraming
            |-> ##[2:200] txFifoWrite;
    endproperty
    a_looped: assert property (p_looped) else $error("not looped");
    property p_swap_wr;
        ctl_reg[2] && !ctl_reg[6] && !ctl_reg[7] && cpuTxWrite && !rxByteValid
            |=> rxFifoWrite && !txFifoWrite && rxFifoInTag == $past(cpuTxTag)
            && rxFifoInData == $past(cpuTxData);
    endproperty
    a_swap_wr: assert property (p_swap_wr) else $error("swap");
    property p_swap_tag;
        (ctl_reg[2] && !ctl_reg[7]) [*4] |-> fifoTagReadBits
            == $past(txFifoOutTag);
    endproperty
    a_swap_tag: assert property (p_swap_tag) else $error("tag");
    property p_tx_loop;
        (ctl_reg[0] && !ctl_reg[7] && !hdlcReset && $stable(txPacketData)) [*4]
            |-> receiverSerialIn == txPacketData;
    endproperty
    a_tx_loop: assert property (p_tx_loop) else $error("tx loop");
endmodule // hdlc_test_asserts
bind hdlc_test_loopback_control hdlc_test_asserts chk (.*);
`default_nettype wire

// ### verif/hdlc_line_model.sv
// Far side serial line feeding the receive serial pins.
// Assumes the bench calls send after setting a serial test bit.
`timescale 1ns/1ps
`default_nettype none
// ****
// Serial line model
// ****
module hdlc_line_model (
    input wire logic core_clk,
    output var logic rxSerialClock,
    output var logic rxLineData
);
    initial begin
        rxSerialClock = 1'b0;
        rxLineData = 1'b1;
    end
    // Clock stands still between frames; data inverts so stale bits fail
    task automatic send(input logic [19:0] bits);
        for (int i = 19; i >= 0; i--) begin
            rxLineData <= bits[i];
            repeat (4) @(posedge core_clk);
            rxSerialClock <= 1'b1;
            repeat (4) @(posedge core_clk);
            rxSerialClock <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
        rxLineData <= ~bits[0];
    endtask
    // Parks the receive clock at a level for the clock monitor
    task automatic park(input logic c);
        rxSerialClock <= c;
    endtask
endmodule // hdlc_line_model
`default_nettype wire

// ### verif/tb_hdlc_test_loopback_control.sv
// Bench for the test and loopback section and its serial line model.
// Assumes packet FIFOs outside; their heads are driven by the bench.
`timescale 1ns/1ps
`default_nettype none
`include "hdlc_test_map.vh"
`define CHK(n, e, g) compares++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("Error %s expected %h seen %h", n, e, g); \
    end
// ****
// Bench top
// ****
module tb_hdlc_test_loopback_control;
    localparam logic [7:0] CTL = `TEST_CTRL_OFS;
    localparam logic [7:0] STS = `TEST_STAT_OFS;
    logic core_clk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic txSerialClock = 1'b0, txPacketData = 1'b0, cpuRxRead = 1'b0;
    logic receiverEnableBit = 1'b0, transmitterEnableBit = 1'b0;
    logic rxByteValid = 1'b0, rxByteIsFraming = 1'b0, cpuTxWrite = 1'b0;
    logic txFifoInReady = 1'b0;
    logic [7:0] regAddr = '0, regWrData = '0, rxByteData = '0, d;
    logic [7:0] cpuTxData = '0, txFifoOutData = '0;
    logic [1:0] rxByteTag = '0, cpuTxTag = '0, txFifoOutTag = '0;
    logic [15:0] stationAddress = '0;
    logic rxSerialClock, rxLineData, rxLoopReady, rxFifoWrite, rxFifoRead;
    logic txFifoWrite, txFifoRead, receiverSerialIn, hdlcReset;
    logic [7:0] regRdData, cpuReadData, rxFifoInData, txFifoInData;
    logic [1:0] fifoTagReadBits, rxFifoInTag, txFifoInTag;
    int n_errors = 0, compares = 0, cyc = 0, k;
    hdlc_test_loopback_control uut (.*, .rxFifoOutData(8'h66),
        .rxFifoOutTag(2'b10));
    hdlc_line_model line (.core_clk(core_clk), .rxSerialClock(rxSerialClock),
        .rxLineData(rxLineData));
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, m, e, input string n);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 d = regRdData;
        `CHK(n, e, d & m)
    endtask
    task automatic rxb(input logic [7:0] v, input logic [1:0] t, input logic f);
        @(posedge core_clk);
        rxByteValid <= 1'b1;
        rxByteData <= v;
        rxByteTag <= t;
        rxByteIsFraming <= f;
        @(posedge core_clk);
        rxByteValid <= 1'b0;
        #1;
    endtask
    // Extra bits after the sixteen must not enter the compare register
    task automatic ser(input logic [7:0] c, mh, input logic [15:0] p,
        input int b, input logic e);
        wr(CTL, 8'h00);
        wr(`CRC_CORRUPT_HI_OFS, mh);
        wr(CTL, c);
        line.send({p, ~p[15:12]});
        repeat (6) @(posedge core_clk);
        rdchk(STS, 8'h01 << b, {7'h00, e} << b, "match");
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        rdchk(CTL, 8'hFF, 8'h00, "ctrl reset");
        rdchk(STS, 8'hF0, 8'h00, "status high");
        wr(STS, 8'hFF);
        rdchk(CTL, 8'hFF, 8'h00, "ctrl");
        rdchk(8'h40, 8'hFF, 8'h00, "unmapped");
        wr(CTL, 8'h80);
        rxb(8'h11, 2'b00, 1'b0);
        `CHK("held write", 1'b0, rxFifoWrite)
        `CHK("hdlc reset", 1'b1, hdlcReset)
        wr(CTL, 8'h00);
        rdchk(CTL, 8'hFF, 8'h80, "one zero");
        wr(CTL, 8'h00);
        rdchk(CTL, 8'hFF, 8'h00, "two zeros");
        `CHK("reset off", 1'b0, hdlcReset)
        wr(CTL, 8'h04);
        cpuTxWrite <= 1'b1;
        cpuTxData <= 8'hA5;
        cpuTxTag <= 2'b10;
        txFifoOutData <= 8'h3C;
        txFifoOutTag <= 2'b01;
        @(posedge core_clk);
        cpuTxWrite <= 1'b0;
        cpuRxRead <= 1'b1;
        #1 `CHK("swap wr", 12'hAA5, ({rxFifoWrite, txFifoWrite, rxFifoInTag, rxFifoInData}))
        @(posedge core_clk);
        cpuRxRead <= 1'b0;
        #1 `CHK("swap rd", 2'b10, ({txFifoRead, rxFifoRead}))
        repeat (3) @(posedge core_clk);
        #1 `CHK("swap head", 10'h13C, ({fifoTagReadBits, cpuReadData}))
        wr(CTL, 8'h00);
        rxb(8'h99, 2'b00, 1'b1);
        `CHK("framing", 1'b0, rxFifoWrite)
        rxb(8'h5A, 2'b01, 1'b0);
        `CHK("rx byte", 11'h55A, ({rxFifoWrite, rxFifoInTag, rxFifoInData}))
        @(posedge core_clk);
        cpuTxWrite <= 1'b1;
        cpuTxData <= 8'h66;
        cpuTxTag <= 2'b10;
        @(posedge core_clk);
        cpuTxWrite <= 1'b0;
        #1 `CHK("copy wr", 11'h666, ({txFifoWrite, txFifoInTag, txFifoInData}))
        `CHK("rx head", 10'h266, ({fifoTagReadBits, cpuReadData}))
        wr(CTL, 8'h40);
        for (k = 0; rxLoopReady === 1'b1 && k < 20; k++) begin
            rxb(k[7:0], {1'b0, k == 15}, 1'b0);
            repeat (3) @(negedge core_clk);
        end
        `CHK("loop depth", 16, k)
        @(posedge core_clk);
        txFifoInReady <= 1'b1;
        k = 0;
        repeat (60) begin
            @(posedge core_clk);
            #1;
            if (txFifoWrite === 1'b1) begin
                `CHK("looped", ({1'b0, k == 15, k[7:0]}), ({txFifoInTag, txFifoInData}))
                k++;
            end
        end
        `CHK("looped count", 16, k)
        wr(CTL, 8'h00);
        receiverEnableBit <= 1'b1;
        stationAddress <= 16'h1234;
        ser(8'h08, 8'h00, 16'hF0B8, 1, 1'b1);
        ser(8'h08, 8'h80, 16'hF0B8, 1, 1'b0);
        ser(8'h08, 8'h80, 16'h70B8, 1, 1'b1);
        ser(8'h02, 8'h00, 16'h1234, 0, 1'b1);
        ser(8'h02, 8'h00, 16'h1235, 0, 1'b0);
        for (k = 0; k < 3; k++) begin
            @(posedge core_clk);
            transmitterEnableBit <= k != 1;
            txSerialClock <= k != 2;
            receiverEnableBit <= k != 1;
            line.park(k != 2);
            repeat (6) @(posedge core_clk);
            rdchk(STS, 8'h0C, {4'h0, k == 0, k == 0, 2'b00}, "clocks");
        end
        wr(CTL, 8'h01);
        for (k = 0; k < 4; k++) begin
            @(posedge core_clk);
            txPacketData <= k[0];
            repeat (6) @(posedge core_clk);
            #1 `CHK("tx loop", k[0], receiverSerialIn)
        end
        wr(CTL, 8'h00);
        @(posedge core_clk);
        txPacketData <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 `CHK("line in", rxLineData, receiverSerialIn)
        stop_test();
    end
endmodule // tb_hdlc_test_loopback_control
`default_nettype wire
